// File: qsr_pkg.sv
// Notes on behaviour
// - option 0 drops at once to switch on disabled with servo off and dynamic brake, in every mode.
// - option 1 ramps the motor down with the mode's own deceleration in non-torque modes, then goes to switch on disabled.
// - options 1 and 5 in cyclic position or velocity mode ramp with the quick stop deceleration.
// - options 1 and 5 in profile position, profile velocity and jog mode ramp with the profile deceleration.
// - options 1 and 5 in homing mode ramp with the homing acceleration.
// - options 1 and 5 in point table mode ramp with the active point table entry's deceleration.
// - option 2 ramps with the quick stop deceleration in all non-torque modes, then goes to switch on disabled.
// - options 1, 2 and 5 in any torque mode go to switch on disabled at once with the dynamic brake.
// - option 5 stays in quick stop active with servo on after the ramp, except in torque modes.
// - option 6 ramps with the quick stop deceleration and stays quick stop active, torque modes brake at once.
package qsr_pkg;
  localparam int DEC_W = 32;
  localparam logic [2:0] OPT_BRAKE = 3'h0;
  localparam logic [2:0] OPT_MODE_OFF = 3'h1;
  localparam logic [2:0] OPT_QSD_OFF = 3'h2;
  localparam logic [2:0] OPT_MODE_HOLD = 3'h5;
  localparam logic [2:0] OPT_QSD_HOLD = 3'h6;
  localparam logic [2:0] OPT_RESET = 3'h2;

  typedef enum logic [3:0] {
    MODE_CSP = 4'h0,
    MODE_CSV = 4'h1,
    MODE_CST = 4'h2,
    MODE_PP = 4'h3,
    MODE_PV = 4'h4,
    MODE_TQ = 4'h5,
    MODE_HOMING = 4'h6,
    MODE_POINT_TABLE = 4'h7,
    MODE_JOG = 4'h8,
    MODE_CONT_TO_TORQUE = 4'h9
  } qsr_mode_e;

  typedef enum logic [1:0] {
    ST_OPERATE = 2'b00,
    ST_RAMP = 2'b01,
    ST_HOLD = 2'b10,
    ST_DISABLED = 2'b11
  } qsr_state_e;

  typedef struct packed {
    logic [DEC_W-1:0] quick_stop;
    logic [DEC_W-1:0] profile;
    logic [DEC_W-1:0] homing;
    logic [DEC_W-1:0] point_table;
  } qsr_decel_s;

  function automatic logic qsr_is_torque(input logic [3:0] m);
    return m == MODE_CST || m == MODE_TQ || m == MODE_CONT_TO_TORQUE;
  endfunction

  function automatic logic qsr_opt_ok(input logic [2:0] c);
    return c == OPT_BRAKE || c == OPT_MODE_OFF || c == OPT_QSD_OFF || c == OPT_MODE_HOLD || c == OPT_QSD_HOLD;
  endfunction
endpackage

// File: qsr_quick_stop_reaction_selector.sv
`timescale 1ns/1ps
module qsr_quick_stop_reaction_selector (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // option code configuration
  input wire logic opt_wr,
  input wire logic [2:0] opt_wdata,
  // drive status inputs
  input wire logic [3:0] mode,
  input wire qsr_pkg::qsr_decel_s decel,
  input wire logic quick_stop_req,
  input wire logic motor_stopped,
  input wire logic restart,
  // reaction outputs
  output logic [2:0] opt_code,
  output logic [1:0] state,
  output logic servo_on,
  output logic dyn_brake,
  output logic ramp_active,
  output logic [qsr_pkg::DEC_W-1:0] ramp_decel
);
  import qsr_pkg::*;

  qsr_state_e state_reg;
  qsr_state_e state_next;
  logic [DEC_W-1:0] sel_decel;
  logic hold_pick;
  logic hold_reg;
  logic is_torque;
  logic immediate;
  logic servo_on_reg;
  logic dyn_brake_reg;
  logic ramp_active_reg;

  assign is_torque = qsr_is_torque(mode);
  // holding codes keep servo on once the ramp has ended
  assign hold_pick = opt_code == OPT_MODE_HOLD || opt_code == OPT_QSD_HOLD;
  // option 0 and every torque mode skip the ramp
  assign immediate = opt_code == OPT_BRAKE || is_torque;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      opt_code <= OPT_RESET;
    end else if (opt_wr && qsr_opt_ok(opt_wdata)) begin
      opt_code <= opt_wdata;
    end
  end

  always_comb begin
    sel_decel = decel.quick_stop;
    if (opt_code == OPT_MODE_OFF || opt_code == OPT_MODE_HOLD) begin
      unique case (mode)
        MODE_PP, MODE_PV, MODE_JOG: sel_decel = decel.profile;
        MODE_HOMING: sel_decel = decel.homing;
        MODE_POINT_TABLE: sel_decel = decel.point_table;
        default: sel_decel = decel.quick_stop;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OPERATE: begin
        if (quick_stop_req) begin
          if (immediate) begin
            state_next = ST_DISABLED;
          end else begin
            state_next = ST_RAMP;
          end
        end
      end
      ST_RAMP: begin
        if (motor_stopped) begin
          state_next = hold_reg ? ST_HOLD : ST_DISABLED;
        end
      end
      ST_HOLD, ST_DISABLED: begin
        if (restart) begin
          state_next = ST_OPERATE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_OPERATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // reaction fixed at request time, a code write during the ramp waits for the next stop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hold_reg <= 1'b0;
    end else if (state_reg == ST_OPERATE && quick_stop_req) begin
      hold_reg <= hold_pick;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ramp_decel <= '0;
    end else if (state_reg == ST_OPERATE && quick_stop_req) begin
      ramp_decel <= sel_decel;
    end
  end

  // flags decoded from the next state so they switch together with state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      servo_on_reg <= 1'b1;
      dyn_brake_reg <= 1'b0;
      ramp_active_reg <= 1'b0;
    end else begin
      servo_on_reg <= state_next != ST_DISABLED;
      dyn_brake_reg <= state_next == ST_DISABLED;
      ramp_active_reg <= state_next == ST_RAMP;
    end
  end

  assign state = state_reg;
  assign servo_on = servo_on_reg;
  assign dyn_brake = dyn_brake_reg;
  assign ramp_active = ramp_active_reg;

  chk_brake_immediate: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_BRAKE) |=> state_reg == ST_DISABLED)
    else $error("option 0 did not brake at once");
  chk_torque_brake: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && is_torque) |=> (dyn_brake && !servo_on))
    else $error("torque mode did not brake at once");
  chk_ramp_start: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code != OPT_BRAKE && !is_torque) |=> ramp_active)
    else $error("ramp not started");
  chk_off_after: assert property (@(posedge clock) disable iff (!rstn)
    (ramp_active && motor_stopped && !hold_reg) |=> state_reg == ST_DISABLED)
    else $error("not disabled after ramp");
  chk_hold_after: assert property (@(posedge clock) disable iff (!rstn)
    (ramp_active && motor_stopped && hold_reg) |=> (state_reg == ST_HOLD && servo_on))
    else $error("not holding after ramp");
  chk_qsd_source: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && (opt_code == OPT_QSD_OFF || opt_code == OPT_QSD_HOLD))
    |=> ramp_decel == $past(decel.quick_stop))
    else $error("quick stop decel not used");
  chk_profile_src: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_OFF && mode == MODE_PP)
    |=> ramp_decel == $past(decel.profile))
    else $error("profile decel not used");
  chk_homing_src: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_HOLD && mode == MODE_HOMING)
    |=> ramp_decel == $past(decel.homing))
    else $error("homing decel not used");
  chk_table_src: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_OFF && mode == MODE_POINT_TABLE)
    |=> ramp_decel == $past(decel.point_table))
    else $error("point table decel not used");
  chk_cyclic_src: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_HOLD && mode == MODE_CSV)
    |=> ramp_decel == $past(decel.quick_stop))
    else $error("cyclic decel not used");
  chk_bad_code: assert property (@(posedge clock) disable iff (!rstn)
    (opt_wr && !qsr_opt_ok(opt_wdata)) |=> $stable(opt_code))
    else $error("bad option code accepted");
  chk_good_code: assert property (@(posedge clock) disable iff (!rstn)
    (opt_wr && qsr_opt_ok(opt_wdata)) |=> opt_code == $past(opt_wdata))
    else $error("legal option code not taken");
  chk_jog_src: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_HOLD && mode == MODE_JOG)
    |=> ramp_decel == $past(decel.profile))
    else $error("jog decel not used");
  chk_pv_src: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_OFF && mode == MODE_PV)
    |=> ramp_decel == $past(decel.profile))
    else $error("profile velocity decel not used");
  chk_csp_src: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_OFF && mode == MODE_CSP)
    |=> ramp_decel == $past(decel.quick_stop))
    else $error("cyclic position decel not used");
  chk_table_hold: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_HOLD && mode == MODE_POINT_TABLE)
    |=> ramp_decel == $past(decel.point_table))
    else $error("point table decel not used on hold");
  chk_homing_off: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_OFF && mode == MODE_HOMING)
    |=> ramp_decel == $past(decel.homing))
    else $error("homing decel not used on off");
  chk_qsd_torque: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_QSD_HOLD && is_torque)
    |=> (state_reg == ST_DISABLED && dyn_brake))
    else $error("option 6 torque did not brake");
  chk_qsd_hold_ramp: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_QSD_HOLD && !is_torque)
    |=> ramp_active)
    else $error("option 6 did not ramp");
  chk_mode_off_torque: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_OPERATE && quick_stop_req && opt_code == OPT_MODE_OFF && mode == MODE_CONT_TO_TORQUE)
    |=> state_reg == ST_DISABLED)
    else $error("continuous torque did not brake");
  chk_hold_servo: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == ST_HOLD |-> (servo_on && !dyn_brake))
    else $error("servo dropped while holding");
  chk_hold_stay: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_HOLD && !restart) |=> state_reg == ST_HOLD)
    else $error("hold left without restart");
  chk_disabled_stay: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == ST_DISABLED && !restart) |=> (state_reg == ST_DISABLED && dyn_brake))
    else $error("disabled left without restart");
  chk_brake_servo: assert property (@(posedge clock) disable iff (!rstn)
    dyn_brake |-> !servo_on)
    else $error("brake with servo on");
  chk_ramp_holds: assert property (@(posedge clock) disable iff (!rstn)
    (ramp_active && !motor_stopped) |=> ramp_active)
    else $error("ramp ended before standstill");
  chk_ramp_flags: assert property (@(posedge clock) disable iff (!rstn)
    ramp_active |-> (servo_on && !dyn_brake && state_reg == ST_RAMP))
    else $error("ramp flags wrong");
  chk_decel_kept: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg != ST_OPERATE) |=> $stable(ramp_decel))
    else $error("ramp decel changed after request");
endmodule // qsr_quick_stop_reaction_selector

// File: qsr_ctrl_model.sv
`timescale 1ns/1ps
module qsr_ctrl_model (
  // clock
  input wire logic clock,
  // drive side
  input wire logic ramp_active,
  input wire logic [2:0] lag,
  output logic motor_stopped
);
  logic [2:0] cnt_reg = 3'h0;
  initial motor_stopped = 1'b0;
  // motor reports standstill only after lag cycles of ramping
  always @(posedge clock) begin
    cnt_reg <= ramp_active ? cnt_reg + 3'h1 : 3'h0;
    motor_stopped <= #1 ramp_active && cnt_reg >= lag;
  end
endmodule // qsr_ctrl_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import qsr_pkg::*;
  logic clock = 0, rstn = 0, opt_wr = 0, qs = 0, restart = 0, ms, servo_on, dyn_brake, ramp_active;
  logic [2:0] wd = 3'h0, lag = 3'h0, opt_code;
  logic [3:0] mode = 4'h0;
  logic [1:0] state;
  logic [DEC_W-1:0] ramp_decel;
  qsr_decel_s decel = '0;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  int errors = 0, total_checks = 0;
  always #5 clock = ~clock;
  qsr_quick_stop_reaction_selector DUT (.clock, .rstn, .opt_wr, .opt_wdata(wd), .mode, .decel, .quick_stop_req(qs),
    .motor_stopped(ms), .restart, .opt_code, .state, .servo_on, .dyn_brake, .ramp_active, .ramp_decel);
  qsr_ctrl_model PM (.clock, .ramp_active, .lag, .motor_stopped(ms));
  task chk(string n, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task step;
    @(posedge clock);
    #1;
  endtask
  task wr(logic [2:0] c);
    opt_wr = 1;
    wd = c;
    step;
    opt_wr = 0;
    step;
  endtask
  task chk_reset;
    chk("reset opt", 3'h2, opt_code);
    chk("reset state", 2'h0, state);
    chk("reset flags", 3'b100, {servo_on, dyn_brake, ramp_active});
    chk("reset decel", 32'h0, ramp_decel);
  endtask
  function logic [31:0] dec(logic [2:0] o, logic [3:0] m);
    if (o == 3'h2 || o == 3'h6 || m <= 4'h1) return decel.quick_stop;
    if (m == 4'h6) return decel.homing;
    if (m == 4'h7) return decel.point_table;
    return decel.profile;
  endfunction
  task react(logic [2:0] o, logic [3:0] m);
    logic imm;
    logic [1:0] f;
    logic [31:0] e;
    imm = o == 3'h0 || m == 4'h2 || m == 4'h5 || m == 4'h9;
    f = (imm || o < 3'h5) ? 2'h3 : 2'h2;
    wr(o);
    mode = m;
    decel = {$urandom, $urandom, $urandom, $urandom};
    lag = 3'($urandom);
    e = dec(o, m);
    qs = 1;
    step;
    chk("state", imm ? 2'h3 : 2'h1, state);
    if (imm) chk("brake", 3'b010, {servo_on, dyn_brake, ramp_active});
    else begin
      chk("decel", e, ramp_decel);
      chk("ramp", 3'b101, {servo_on, dyn_brake, ramp_active});
    end
    decel = ~decel;
    step;
    qs = 0;
    if (!imm) chk("held decel", e, ramp_decel);
    repeat (20) if (state === 2'h1) step;
    chk("final", f, state);
    chk("servo", {f == 2'h2, f == 2'h3, 1'b0}, {servo_on, dyn_brake, ramp_active});
    restart = 1;
    step;
    restart = 0;
    $display("test option %0d mode %0d done", o, m);
  endtask
  initial begin
    void'($urandom(36960));
    repeat (10) @(posedge clock);
    #1 rstn = 1;
    chk_reset;
    $display("test reset done");
    foreach (codes[i]) for (int m = 0; m < 10; m++) react(codes[i], 4'(m));
    wr(3'h5);
    foreach (codes[i]) wr(3'h3 + 3'(i % 3) + (i % 3 == 2 ? 3'h2 : 3'h0));
    chk("illegal opt", 3'h5, opt_code);
    $display("test illegal codes done");
    wr(3'h6);
    mode = 4'h3;
    lag = 3'h7;
    qs = 1;
    step;
    qs = 0;
    chk("ramp state", 2'h1, state);
    rstn = 0;
    #1 chk_reset;
    step;
    rstn = 1;
    chk_reset;
    $display("test reset in ramp done");
    repeat (30) react(codes[$urandom % 5], 4'($urandom % 10));
    conclude;
  end
  initial begin
    #100000;
    errors++;
    conclude;
  end
endmodule // tb_top
